// [shared/rx_dl_cas_defines.vh]
`ifndef RX_DL_CAS_DEFINES_VH
`define RX_DL_CAS_DEFINES_VH
// register offsets
`define RX_SIGNAL_DATALINK_SELECT_ADDR 12'h10c
`define RX_SIGNAL_CHANGE_SLOTS_0_7_ADDR 12'h10d
`define RX_SIGNAL_CHANGE_SLOTS_8_15_ADDR 12'h10e
`define RX_SIGNAL_CHANGE_SLOTS_16_23_ADDR 12'h10f
// select register field and reset
`define ROUTE_SEL_LSB 0
`define ROUTE_SEL_MSB 1
`define ROUTE_SEL_RESET 2'h0
`define CHANGE_RESET 8'h00
// route encodings
`define ROUTE_LAPD_SERIAL 2'h0
`define ROUTE_SERIAL_ONLY 2'h1
`define ROUTE_OVERHEAD_SERIAL 2'h2
`define ROUTE_FORCE_ONE 2'h3
`endif

// [core/skid_buffer2.v]
`timescale 1ns/1ps
// two-entry buffer, full-throughput, loses no word on a stall
module skid_buffer2 #(
	parameter WIDTH = 2
) (
	// clock and reset
	input wire mclk,
	input wire rst_b,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:1];
	reg rd_ptr;
	reg wr_ptr;
	reg [1:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// pointers and occupancy
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push & ~pop)
				count <= count + 2'h1;
			else if (pop & ~push)
				count <= count - 2'h1;
		end
	end

	// storage, no reset needed
	always @(posedge mclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// [core/rx_datalink_route_cas_change.v]
// Overview of operation
// - select 00 sends each data-link bit to lapd controller one and serial.
// - select 01 sends data-link bits to serial output only, no lapd.
// - select 10 sends data-link bits to overhead and serial outputs.
// - select 11 replaces every data-link bit with constant one.
// - only lapd controller one may take data-link bits.
// - first change register: bit 7 slot 0 down to bit 0 slot 7.
// - second change register: bit 7 slot 8 down to bit 0 slot 15.
// - third change register: bit 7 slot 16 down to bit 0 slot 23.
// - flag sets when slot signaling differs from value at previous read.
// - reading a change register clears its flags, except one whose slot changes in the same cycle.
// - flags work only while the stream carries channel-associated signaling.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "rx_dl_cas_defines.vh"
module rx_datalink_route_cas_change #(
	parameter ADDR_W = 12,
	parameter SLOTS = 24,
	parameter SIG_W = 4
) (
	// clock and reset
	input wire mclk,
	input wire rst_b,
	// register port
	input wire [ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// recovered data-link bit from framer
	input wire dl_valid,
	output wire dl_ready,
	input wire dl_bit,
	// serial output path
	output reg rx_serial_output,
	output reg rx_serial_valid,
	// overhead output path
	output reg rx_overhead_output,
	output reg rx_overhead_valid,
	// lapd controller one
	output reg lapd1_bit,
	output reg lapd1_valid,
	input wire lapd1_ready,
	// signaling from framer
	input wire cas_mode,
	input wire sig_valid,
	input wire [4:0] sig_slot,
	input wire [SIG_W-1:0] sig_value
);
	// route select register and its decode
	reg [1:0] datalink_route_select;
	reg [1:0] next_route_select;
	reg route_lapd;
	reg route_overhead;
	reg route_force;

	// data-link buffer side
	wire buf_valid;
	wire buf_data;
	wire buf_ready;
	wire buf_take;
	wire route_bit;
	wire lapd_busy;

	// next values of the output registers
	reg next_serial_output;
	reg next_serial_valid;
	reg next_overhead_output;
	reg next_overhead_valid;
	reg next_lapd1_bit;
	reg next_lapd1_valid;

	// register decode strobes
	wire wr_select;
	wire rd_chg0;
	wire rd_chg1;
	wire rd_chg2;
	reg [7:0] next_rdata;

	// signaling bookkeeping
	wire sig_in_range;
	wire sig_take;
	wire [SLOTS-1:0] slot_hit;
	wire [SLOTS-1:0] slot_clear;
	wire [SLOTS-1:0] slot_diff;
	reg [SLOTS-1:0] flag;
	reg [SLOTS-1:0] next_flag;
	wire [7:0] change0;
	wire [7:0] change1;
	wire [7:0] change2;

	// slot ranges of the three change registers
	localparam REG1_FIRST = 8;
	localparam REG2_FIRST = 16;

	always @* begin
		route_lapd = 1'b0;
		route_overhead = 1'b0;
		route_force = 1'b0;
		case (datalink_route_select)
			`ROUTE_LAPD_SERIAL: begin
				route_lapd = 1'b1;
			end
			`ROUTE_SERIAL_ONLY: begin
				route_lapd = 1'b0;
			end
			`ROUTE_OVERHEAD_SERIAL: begin
				route_overhead = 1'b1;
			end
			`ROUTE_FORCE_ONE: begin
				route_force = 1'b1;
			end
			default: begin
				route_lapd = 1'b0;
			end
		endcase
	end

	assign route_bit = route_force ? 1'b1 : buf_data;
	// controller one still holds a bit it has not taken
	assign lapd_busy = lapd1_valid & ~lapd1_ready;
	// stall only when controller one is fed and busy, so no bit is lost
	assign buf_ready = ~route_lapd | ~lapd_busy;
	assign buf_take = buf_valid & buf_ready;

	// data-link bit buffer between framer and outputs
	skid_buffer2 #(
		.WIDTH(1)
	) u_dl_buf (
		.mclk(mclk),
		.rst_b(rst_b),
		.in_valid(dl_valid),
		.in_ready(dl_ready),
		.in_data(dl_bit),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(buf_data)
	);

	always @* begin
		next_serial_output = rx_serial_output;
		// valid pulses once per bit taken from the buffer
		next_serial_valid = buf_take;
		if (buf_take) begin
			next_serial_output = route_bit;
		end
	end

	always @* begin
		next_overhead_output = rx_overhead_output;
		next_overhead_valid = buf_take & route_overhead;
		if (buf_take & route_overhead) begin
			next_overhead_output = route_bit;
		end
	end

	always @* begin
		next_lapd1_bit = lapd1_bit;
		next_lapd1_valid = lapd1_valid;
		// valid holds until the controller takes the bit
		if (buf_take & route_lapd) begin
			next_lapd1_bit = route_bit;
			next_lapd1_valid = 1'b1;
		end else if (lapd1_ready) begin
			next_lapd1_valid = 1'b0;
		end
	end

	// serial output registers, idle level one
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_serial_output <= 1'b1;
			rx_serial_valid <= 1'b0;
		end else begin
			rx_serial_output <= next_serial_output;
			rx_serial_valid <= next_serial_valid;
		end
	end

	// overhead output registers, idle level one
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_overhead_output <= 1'b1;
			rx_overhead_valid <= 1'b0;
		end else begin
			rx_overhead_output <= next_overhead_output;
			rx_overhead_valid <= next_overhead_valid;
		end
	end

	// controller one output registers
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lapd1_bit <= 1'b1;
			lapd1_valid <= 1'b0;
		end else begin
			lapd1_bit <= next_lapd1_bit;
			lapd1_valid <= next_lapd1_valid;
		end
	end

	// register address decode
	assign wr_select = reg_wr && (reg_addr == `RX_SIGNAL_DATALINK_SELECT_ADDR);
	assign rd_chg0 = reg_rd && (reg_addr == `RX_SIGNAL_CHANGE_SLOTS_0_7_ADDR);
	assign rd_chg1 = reg_rd && (reg_addr == `RX_SIGNAL_CHANGE_SLOTS_8_15_ADDR);
	assign rd_chg2 = reg_rd && (reg_addr == `RX_SIGNAL_CHANGE_SLOTS_16_23_ADDR);

	// select register next value
	always @* begin
		next_route_select = datalink_route_select;
		if (wr_select) begin
			next_route_select = reg_wdata[`ROUTE_SEL_MSB:`ROUTE_SEL_LSB];
		end
	end

	// select register
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			datalink_route_select <= `ROUTE_SEL_RESET;
		end else begin
			datalink_route_select <= next_route_select;
		end
	end

	// an out-of-range slot number is dropped
	assign sig_in_range = (sig_slot < SLOTS);
	// signaling is taken only while the stream carries it
	assign sig_take = sig_valid & cas_mode & sig_in_range;

	// per-slot signaling tracking and change detection
	genvar s;
	generate
		for (s = 0; s < SLOTS; s = s + 1) begin : g_slot
			reg [SIG_W-1:0] last_sig;
			reg [SIG_W-1:0] ref_sig;
			// slot selected by the incoming update
			assign slot_hit[s] = sig_take && (sig_slot == s);
			// slot belongs to the register being read
			assign slot_clear[s] = (s < REG1_FIRST) ? rd_chg0 : ((s < REG2_FIRST) ? rd_chg1 : rd_chg2);
			// differs from value at last read
			assign slot_diff[s] = slot_hit[s] && (sig_value != ref_sig);
			// latest value seen for this slot
			always @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					last_sig <= {SIG_W{1'b0}};
				end else if (slot_hit[s]) begin
					last_sig <= sig_value;
				end
			end
			// reference value taken at each clearing read while cas_mode is set
			always @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					ref_sig <= {SIG_W{1'b0}};
				end else if (cas_mode && slot_clear[s]) begin
					ref_sig <= last_sig;
				end
			end
		end
	endgenerate

	// next flag values
	always @* begin
		next_flag = flag;
		if (!cas_mode) begin
			next_flag = {SLOTS{1'b0}};
		end else begin
			next_flag = flag & ~slot_clear;
			next_flag = next_flag | slot_diff;
		end
	end

	// change flags, one per slot
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= {SLOTS{1'b0}};
		end else begin
			flag <= next_flag;
		end
	end

	// slot 0 at bit 7 down to slot 7 at bit 0
	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1) begin : g_pack0
			assign change0[7 - b] = flag[b];
		end
	endgenerate

	// slot 8 at bit 7 down to slot 15 at bit 0
	generate
		for (b = 0; b < 8; b = b + 1) begin : g_pack1
			assign change1[7 - b] = flag[REG1_FIRST + b];
		end
	endgenerate

	// slot 16 at bit 7 down to slot 23 at bit 0
	generate
		for (b = 0; b < 8; b = b + 1) begin : g_pack2
			assign change2[7 - b] = flag[REG2_FIRST + b];
		end
	endgenerate

	// read data mux; unmapped addresses read zero
	always @* begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`RX_SIGNAL_DATALINK_SELECT_ADDR: begin
					next_rdata = {6'h00, datalink_route_select};
				end
				`RX_SIGNAL_CHANGE_SLOTS_0_7_ADDR: begin
					next_rdata = change0;
				end
				`RX_SIGNAL_CHANGE_SLOTS_8_15_ADDR: begin
					next_rdata = change1;
				end
				`RX_SIGNAL_CHANGE_SLOTS_16_23_ADDR: begin
					next_rdata = change2;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule

// [dv/lapd_sink_model.sv]
`timescale 1ns/1ps
// lapd controller one, can stall every other cycle
module lapd_sink_model (
	// clock and reset
	input wire mclk,
	input wire rst_b,
	// handshake
	input wire slow,
	output reg lapd1_ready
);
	// ready toggles while slow, else stays high
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
			lapd1_ready <= 1'b0;
		else
			lapd1_ready <= slow ? ~lapd1_ready : 1'b1;
endmodule

// [dv/rx_dl_cas_monitor.sv]
`timescale 1ns/1ps
module rx_dl_cas_monitor #(parameter ADDR_W = 12) (
	// register port
	input wire mclk,
	input wire rst_b,
	input wire [ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// data-link outputs
	input wire rx_serial_output,
	input wire rx_serial_valid,
	input wire rx_overhead_valid,
	input wire lapd1_bit,
	input wire lapd1_valid,
	input wire lapd1_ready,
	input wire cas_mode
);
	reg [1:0] sel;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// shadow of the route select
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
			sel <= 2'h0;
		else if (reg_wr && reg_addr == 'h10c)
			sel <= reg_wdata[1:0];
	rd_sel_a:
	assert property ($past(reg_rd && reg_addr == 'h10c) |-> reg_rdata[1:0] == $past(sel)) else $error("sel");
	lapd_hold_a:
	assert property (lapd1_valid && !lapd1_ready |=> lapd1_valid && $stable(lapd1_bit)) else $error("hold");
	ovh_route_a:
	assert property (rx_overhead_valid |-> $past(sel) == 2'h2 && rx_serial_valid) else $error("ovh");
	force_one_a:
	assert property (rx_serial_valid && $past(sel) == 2'h3 |-> rx_serial_output) else $error("one");
	lapd_route_a:
	assert property (lapd1_valid |-> sel == 2'h0) else $error("lapd");
	rd_idle_a:
	assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("idle");
	unmapped_rd_a:
	assert property ($past(reg_rd && reg_addr[ADDR_W-1:2] != 'h43) |-> reg_rdata == 8'h00) else $error("map");
	cas_off_a:
	assert property ($past(reg_rd && !cas_mode && reg_addr[1:0] != 2'h0) && !$past(cas_mode, 2)
		|-> reg_rdata == 8'h00) else $error("cas");
	cover property (rx_overhead_valid);
	cover property (lapd1_valid && !lapd1_ready);
	cover property ($past(reg_rd) && reg_rdata == 8'hff);
endmodule
bind rx_datalink_route_cas_change rx_dl_cas_monitor #(.ADDR_W(ADDR_W)) u_rx_dl_cas_monitor (
	.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_serial_output,
	.rx_serial_valid, .rx_overhead_valid, .lapd1_bit, .lapd1_valid, .lapd1_ready, .cas_mode);

// [dv/test_rx_datalink_route_cas_change.sv]
`timescale 1ns/1ps
module test_rx_datalink_route_cas_change;
	reg mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, dl_valid = 0, dl_bit = 0;
	reg cas_mode = 0, sig_valid = 0, slow = 0, last_ser = 0, last_ovh = 1, last_lap = 1;
	reg [11:0] reg_addr = 12'h000;
	reg [7:0] reg_wdata = 8'h00;
	reg [4:0] sig_slot = 5'h00;
	reg [3:0] sig_value = 4'h0;
	wire [7:0] reg_rdata;
	wire dl_ready, ser, ser_v, ovh, ovh_v, lapd_b, lapd_v, lapd_r;
	integer n_mismatch = 0, n_checks = 0, cyc = 0, n_ser = 0, n_ovh = 0, n_lap = 0, i;
	always #2 mclk = ~mclk;
	rx_datalink_route_cas_change u_rx_datalink_route_cas_change (.mclk, .rst_b, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dl_valid, .dl_ready, .dl_bit,
		.rx_serial_output(ser), .rx_serial_valid(ser_v), .rx_overhead_output(ovh),
		.rx_overhead_valid(ovh_v), .lapd1_bit(lapd_b), .lapd1_valid(lapd_v), .lapd1_ready(lapd_r),
		.cas_mode, .sig_valid, .sig_slot, .sig_value);
	lapd_sink_model u_lapd_sink_model (.mclk, .rst_b, .slow, .lapd1_ready(lapd_r));
	// counts deliveries per output and cuts a hang short
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		n_ser <= n_ser + ser_v;
		n_ovh <= n_ovh + ovh_v;
		n_lap <= n_lap + (lapd_v & lapd_r);
		if (ser_v)
			last_ser <= ser;
		if (ovh_v)
			last_ovh <= ovh;
		if (lapd_v & lapd_r)
			last_lap <= lapd_b;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			complete_run;
		end
	end
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cmp(input [7:0] got, input [7:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [11:0] a, input [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, e);
	endtask
	// one signaling update, optionally with a read of the first change register
	task sig(input [4:0] s, input [3:0] v, input r);
		@(posedge mclk);
		{sig_valid, sig_slot, sig_value, reg_addr, reg_rd} <= {1'b1, s, v, 12'h10d, r};
		@(posedge mclk);
		{sig_valid, reg_rd} <= 2'h0;
	endtask
	// one data-link bit, held until the buffer takes it
	task send(input b);
		@(posedge mclk);
		{dl_valid, dl_bit} <= {1'b1, b};
		@(negedge mclk);
		while (!dl_ready) @(negedge mclk);
		@(posedge mclk);
		dl_valid <= 1'b0;
	endtask
	task route(input [1:0] s, input [7:0] e, input [1:0] e2);
		wr(12'h10c, {6'h00, s});
		rd(12'h10c, {6'h00, s});
		{n_ser, n_ovh, n_lap} = 0;
		{last_ovh, last_lap} = 2'h3;
		send(1'b0);
		repeat (10) @(posedge mclk);
		#1 cmp({n_ser[1:0], n_ovh[1:0], n_lap[1:0], 1'b0, last_ser}, e);
		cmp({6'h00, last_ovh, last_lap}, {6'h00, e2});
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		wr(12'h110, 8'hff);
		for (i = 0; i < 5; i = i + 1)
			rd(12'h10c + i[11:0], 8'h00);
		cas_mode <= 1'b1;
		for (i = 0; i < 24; i = i + 1)
			sig(i[4:0], 4'h9, 1'b0);
		for (i = 0; i < 3; i = i + 1)
			rd(12'h10d + i[11:0], 8'hff);
		sig(5'h00, 4'h1, 1'b0);
		sig(5'h07, 4'h9, 1'b0);
		sig(5'h0f, 4'h1, 1'b0);
		sig(5'h10, 4'h1, 1'b0);
		rd(12'h10d, 8'h80);
		rd(12'h10e, 8'h01);
		rd(12'h10f, 8'h80);
		rd(12'h10d, 8'h00);
		sig(5'h01, 4'h3, 1'b1);
		rd(12'h10d, 8'h40);
		cas_mode <= 1'b0;
		sig(5'h02, 4'h7, 1'b0);
		rd(12'h10d, 8'h00);
		route(2'h0, 8'h44, 2'h2);
		route(2'h1, 8'h40, 2'h3);
		route(2'h2, 8'h50, 2'h1);
		route(2'h3, 8'h41, 2'h3);
		wr(12'h10c, 8'h00);
		slow <= 1'b1;
		{n_ser, n_lap} = 0;
		repeat (6) send(1'b1);
		repeat (40) @(posedge mclk);
		#1 cmp({n_lap[3:0], n_ser[3:0]}, 8'h66);
		complete_run;
	end
endmodule
